/* File: serial_baud_rate_generator.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_baud_rate_generator
  import rate_gen_pkg::*;
(
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  // Register port
  input  wire logic [rate_gen_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [rate_gen_pkg::DATA_W-1:0] regWrData,
  input  wire logic                           regWrStrobe,
  input  wire logic                           regRdStrobe,
  output logic      [rate_gen_pkg::DATA_W-1:0] regRdData,
  // Status from the serial port
  input  wire logic                           receiverIdleFlag,
  input  wire logic                           txShiftEmpty,
  input  wire logic [2:0]                     rxErrorBits,
  // Timing out
  output logic                                rateTick,
  output logic                                bitTick,
  output rate_gen_pkg::rate_cfg_t             rateCfg
);
  import rate_gen_pkg::*;

  // ==========================================================================
  // Register state
  reg_req_t          req;
  logic [DATA_W-1:0] rateControl_reg;
  logic [DATA_W-1:0] receiveCtrl_reg;
  logic [DATA_W-1:0] divisorLow_reg;
  logic [DATA_W-1:0] divisorHigh_reg;
  logic [DATA_W-1:0] transmitCtrl_reg;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;
  logic              restart_reg;
  logic              rateTick_reg;
  logic              bitTick_reg;
  logic [PRE_W-1:0]  prescale_reg;
  logic [PRE_W-1:0]  prescale_next;

  assign req = '{wrStrobe: regWrStrobe, rdStrobe: regRdStrobe,
                 addr: regAddr, wrData: regWrData};

  function automatic logic hit(input reg_req_t r,
                               input logic [ADDR_W-1:0] idx);
    hit = r.wrStrobe && (r.addr == idx);
  endfunction : hit

  // Masked write keeps read-only bits at zero in storage
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] nw,
                                              input logic [DATA_W-1:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  wire wrRateControl = hit(req, RATE_CONTROL_IDX);
  wire wrReceiveCtrl = hit(req, RECEIVE_STATUS_CONTROL_IDX);
  wire wrDivLow      = hit(req, RATE_DIVISOR_LOW_IDX);
  wire wrDivHigh     = hit(req, RATE_DIVISOR_HIGH_IDX);
  wire wrTransmit    = hit(req, TRANSMIT_STATUS_CONTROL_IDX);
  wire divisorWrite  = wrDivLow || wrDivHigh;

  // ==========================================================================
  // Mode decode
  wire wideSel   = rateControl_reg[WIDE_COUNTER_SELECT_BIT]; // R01 R14
  wire syncMode  = transmitCtrl_reg[LINK_MODE_BIT];          // R12
  wire highSpeed = transmitCtrl_reg[HIGH_SPEED_SELECT_BIT];  // R13

  // Upper byte is masked off in 8-bit mode
  wire [CNT_W-1:0] effDivisor = wideSel ? {divisorHigh_reg, divisorLow_reg}
                                        : {8'h00, divisorLow_reg}; // R11 R10

  function automatic logic [PRE_W-1:0] preLimitOf(input logic sm,
                                                  input logic wd,
                                                  input logic hs);
    if (sm) begin
      preLimitOf = PRE_LIMIT_4;              // R04 R06 R10
    end else if (!wd && !hs) begin
      preLimitOf = PRE_LIMIT_64;             // R03 R06
    end else if (wd && hs) begin
      preLimitOf = PRE_LIMIT_4;              // R10
    end else begin
      preLimitOf = PRE_LIMIT_16;             // R03 R06
    end
  endfunction : preLimitOf

  wire [PRE_W-1:0] preLimit = preLimitOf(syncMode, wideSel, highSpeed);

  // ==========================================================================
  // Register writes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rateControl_reg  <= REG_RESET; // R01
      receiveCtrl_reg  <= REG_RESET;
      divisorLow_reg   <= REG_RESET;
      divisorHigh_reg  <= REG_RESET;
      transmitCtrl_reg <= REG_RESET;
    end else begin
      if (wrRateControl) begin
        rateControl_reg <= merge(rateControl_reg, req.wrData,
                                 RATE_CONTROL_WMASK); // R14
      end
      if (wrReceiveCtrl) begin
        receiveCtrl_reg <= merge(receiveCtrl_reg, req.wrData,
                                 RECEIVE_CTRL_WMASK);
      end
      if (wrDivLow) begin
        divisorLow_reg <= req.wrData;
      end
      if (wrDivHigh) begin
        divisorHigh_reg <= req.wrData;
      end
      if (wrTransmit) begin
        transmitCtrl_reg <= merge(transmitCtrl_reg, req.wrData,
                                  TRANSMIT_CTRL_WMASK); // R12 R13
      end
    end
  end

  // ==========================================================================
  // Read port; status bits come live from the serial port
  logic [DATA_W-1:0] rateControlView;
  logic [DATA_W-1:0] receiveCtrlView;
  logic [DATA_W-1:0] transmitCtrlView;

  always_comb begin
    rateControlView = rateControl_reg;
    rateControlView[RECEIVER_IDLE_FLAG_BIT] = receiverIdleFlag; // R07
    receiveCtrlView = {receiveCtrl_reg[7:3], rxErrorBits};
    transmitCtrlView = transmitCtrl_reg;
    transmitCtrlView[TX_SHIFT_EMPTY_BIT] = txShiftEmpty;
  end

  always_comb begin
    unique case (req.addr)
      RATE_CONTROL_IDX:            rdData_next = rateControlView;
      RECEIVE_STATUS_CONTROL_IDX:  rdData_next = receiveCtrlView;
      RATE_DIVISOR_LOW_IDX:        rdData_next = divisorLow_reg;
      RATE_DIVISOR_HIGH_IDX:       rdData_next = divisorHigh_reg;
      TRANSMIT_STATUS_CONTROL_IDX: rdData_next = transmitCtrlView;
      default:                     rdData_next = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= req.rdStrobe ? rdData_next : '0;
    end
  end

  // ==========================================================================
  // Rate counter and prescaler
  logic [CNT_W-1:0] rateCount;
  logic             rateWrap;

  // Restart one cycle after the write so the new bytes are already stored
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= divisorWrite; // R05
    end
  end

  rate_down_counter #(
    .WIDTH(CNT_W)
  ) u_rate_counter (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load     (restart_reg),
    .loadValue(effDivisor),
    .count    (rateCount),
    .wrap     (rateWrap)
  ); // R02 R09

  // Compare with >= so a smaller multiplier set mid-count cannot overrun
  wire preDone = rateWrap && (prescale_reg >= preLimit);

  assign prescale_next = restart_reg ? '0 :
                         preDone     ? '0 :
                         rateWrap    ? prescale_reg + 1'b1 : prescale_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prescale_reg <= '0;
      rateTick_reg <= 1'b0;
      bitTick_reg  <= 1'b0;
    end else begin
      prescale_reg <= prescale_next; // R05
      rateTick_reg <= rateWrap;      // R02
      bitTick_reg  <= preDone;       // R03 R06
    end
  end

  assign regRdData = rdData_reg;
  assign rateTick  = rateTick_reg;
  assign bitTick   = bitTick_reg;
  assign rateCfg   = '{syncMode: syncMode, wideSel: wideSel,
                       highSpeed: highSpeed};

  // ==========================================================================
  // Checking helpers
  logic [CNT_W-1:0] sinceTick_reg;
  logic             periodDisturbed_reg;
  logic [PRE_W-1:0] ticksSinceBit_reg;
  logic             modeDisturbed_reg;
  logic             rateCtlWrite_reg;
  // Width change lands one cycle late; a reload at that wrap is stale
  wire anyRateWrite = divisorWrite || wrRateControl || restart_reg ||
                      rateCtlWrite_reg;
  wire anyModeWrite = anyRateWrite || wrTransmit;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sinceTick_reg       <= '0;
      periodDisturbed_reg <= 1'b1;
      ticksSinceBit_reg   <= '0;
      modeDisturbed_reg   <= 1'b1;
      rateCtlWrite_reg    <= 1'b0;
    end else begin
      rateCtlWrite_reg <= wrRateControl;
      sinceTick_reg <= rateTick_reg ? '0 : sinceTick_reg + 1'b1;
      if (anyRateWrite) begin
        periodDisturbed_reg <= 1'b1;
      end else if (rateTick_reg) begin
        periodDisturbed_reg <= 1'b0;
      end
      if (bitTick_reg) begin
        ticksSinceBit_reg <= '0;
      end else if (rateTick_reg) begin
        ticksSinceBit_reg <= ticksSinceBit_reg + 1'b1;
      end
      if (anyModeWrite) begin
        modeDisturbed_reg <= 1'b1;
      end else if (bitTick_reg) begin
        modeDisturbed_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Assertions
  property p_narrow_after_reset;
    @(posedge ref_clk) $fell(sys_rst) |-> !rateCfg.wideSel;
  endproperty
  a_narrow_after_reset: assert property (p_narrow_after_reset) // R01
    else $error("counter not 8-bit after reset");

  property p_period;
    @(posedge ref_clk) disable iff (sys_rst)
      rateTick_reg && !periodDisturbed_reg |-> sinceTick_reg == effDivisor;
  endproperty
  a_period: assert property (p_period) // R02
    else $error("rate tick period is not divisor plus one");

  property p_multiplier;
    @(posedge ref_clk) disable iff (sys_rst)
      bitTick_reg && !modeDisturbed_reg |-> ticksSinceBit_reg == preLimit;
  endproperty
  a_multiplier: assert property (p_multiplier) // R03
    else $error("bit tick spacing does not match multiplier");

  property p_sync_ignores_speed;
    @(posedge ref_clk) disable iff (sys_rst)
      bitTick_reg && !modeDisturbed_reg && rateCfg.syncMode |->
        ticksSinceBit_reg == PRE_LIMIT_4;
  endproperty
  a_sync_ignores_speed: assert property (p_sync_ignores_speed) // R04
    else $error("synchronous multiplier depends on high speed");

  property p_restart;
    @(posedge ref_clk) disable iff (sys_rst)
      divisorWrite |=> restart_reg ##1
        (rateCount == $past(effDivisor) && prescale_reg == 6'h00);
  endproperty
  a_restart: assert property (p_restart) // R05
    else $error("divisor write did not restart the counter");

  property p_async_low_64;
    @(posedge ref_clk) disable iff (sys_rst)
      bitTick_reg && !modeDisturbed_reg && !syncMode && !wideSel &&
        !highSpeed |-> ticksSinceBit_reg == PRE_LIMIT_64;
  endproperty
  a_async_low_64: assert property (p_async_low_64) // R06
    else $error("async 8-bit low speed multiplier is not 64");

  property p_bit_on_rate;
    @(posedge ref_clk) disable iff (sys_rst) bitTick_reg |-> rateTick_reg;
  endproperty
  a_bit_on_rate: assert property (p_bit_on_rate) // R09
    else $error("bit tick without a rate tick");

  property p_wide_fast_4;
    @(posedge ref_clk) disable iff (sys_rst)
      bitTick_reg && !modeDisturbed_reg && wideSel &&
        (highSpeed || syncMode) |-> ticksSinceBit_reg == PRE_LIMIT_4;
  endproperty
  a_wide_fast_4: assert property (p_wide_fast_4) // R10
    else $error("16-bit fast multiplier is not 4");

  property p_low_byte_only;
    @(posedge ref_clk) disable iff (sys_rst)
      rateTick_reg && !periodDisturbed_reg && !rateCfg.wideSel |->
        sinceTick_reg == {8'h00, divisorLow_reg};
  endproperty
  a_low_byte_only: assert property (p_low_byte_only) // R11
    else $error("high divisor byte used in 8-bit mode");

  property p_mode_bits;
    @(posedge ref_clk) disable iff (sys_rst)
      wrTransmit |=> rateCfg.syncMode == $past(regWrData[4]) &&
                     rateCfg.highSpeed == $past(regWrData[2]);
  endproperty
  a_mode_bits: assert property (p_mode_bits) // R12 R13
    else $error("mode bits not taken from transmit control");

  property p_wide_bit;
    @(posedge ref_clk) disable iff (sys_rst)
      wrRateControl |=> rateCfg.wideSel == $past(regWrData[3]);
  endproperty
  a_wide_bit: assert property (p_wide_bit) // R14
    else $error("wide select not taken from rate control");

  c_sync_bit: cover property (@(posedge ref_clk) bitTick_reg && syncMode);
  c_wide_bit: cover property (@(posedge ref_clk) bitTick_reg && wideSel);
  c_restart:  cover property (@(posedge ref_clk) restart_reg);

endmodule : serial_baud_rate_generator
`default_nettype wire

/* File: rate_gen_pkg.sv */
// Function
// R01 - Rate counter is 8-bit after reset, 16-bit once wide select is set.
// R02 - Rate counter runs freely, period set by the divisor byte pair.
// R03 - Async multiplier depends on both high-speed and wide select bits.
// R04 - In synchronous mode the high-speed select bit is ignored.
// R05 - Any divisor byte write clears the rate counter, new rate at once.
// R06 - Fosc/(M(n+1)), M 64 async 8b slow, 16 8b fast or 16b slow, 4 8b sync.
// R07 - Software checks the receiver idle flag before a system clock change.
// R08 - Software picks high speed or 16-bit to cut error, 16-bit for slow.
// R09 - One rate counter times both asynchronous and synchronous operation.
// R10 - Async 16-bit fast and 16-bit sync give Fosc/(4(n+1)), full divisor.
// R11 - With the 8-bit counter only the low divisor byte sets the period.
// R12 - Bit 4 of transmit status and control is one for synchronous mode.
// R13 - Bit 2 of transmit status and control selects async high speed.
// R14 - Bit 3 of rate control selects the 16-bit counter when one.
package rate_gen_pkg;

  // ==========================================================================
  // Register port
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;
  localparam int PRE_W  = 6;

  localparam logic [ADDR_W-1:0] RATE_CONTROL_IDX            = 3'h0;
  localparam logic [ADDR_W-1:0] RECEIVE_STATUS_CONTROL_IDX  = 3'h1;
  localparam logic [ADDR_W-1:0] RATE_DIVISOR_LOW_IDX        = 3'h2;
  localparam logic [ADDR_W-1:0] RATE_DIVISOR_HIGH_IDX       = 3'h3;
  localparam logic [ADDR_W-1:0] TRANSMIT_STATUS_CONTROL_IDX = 3'h4;

  // ==========================================================================
  // Field positions
  localparam int WIDE_COUNTER_SELECT_BIT = 3;
  localparam int RECEIVER_IDLE_FLAG_BIT  = 6;
  localparam int LINK_MODE_BIT           = 4;
  localparam int HIGH_SPEED_SELECT_BIT   = 2;
  localparam int TX_SHIFT_EMPTY_BIT      = 1;

  // Writable bits; the rest read back status or zero
  localparam logic [DATA_W-1:0] RATE_CONTROL_WMASK = 8'h1b;
  localparam logic [DATA_W-1:0] RECEIVE_CTRL_WMASK = 8'hf8;
  localparam logic [DATA_W-1:0] TRANSMIT_CTRL_WMASK = 8'hfd;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // ==========================================================================
  // Prescale limits (multiplier minus one)
  localparam logic [PRE_W-1:0] PRE_LIMIT_64 = 6'h3f;
  localparam logic [PRE_W-1:0] PRE_LIMIT_16 = 6'h0f;
  localparam logic [PRE_W-1:0] PRE_LIMIT_4  = 6'h03;

  typedef struct packed {
    logic syncMode;
    logic wideSel;
    logic highSpeed;
  } rate_cfg_t;

  typedef struct packed {
    logic                  wrStrobe;
    logic                  rdStrobe;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wrData;
  } reg_req_t;

endpackage : rate_gen_pkg

/* File: rate_down_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module rate_down_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  // Status
  output logic      [WIDTH-1:0] count,
  output logic                  wrap
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // Reload on terminal count gives a period of loadValue + 1
  assign wrap       = (count_reg == '0) && !load;
  assign count_next = (load || wrap) ? loadValue : count_reg - 1'b1;
  assign count      = count_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : rate_down_counter
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rate_gen_pkg::*;

  // ==========================================================================
  // Stimulus and observed signals
  logic                ref_clk;
  logic                sys_rst;
  logic [ADDR_W-1:0]   regAddr;
  logic [DATA_W-1:0]   regWrData;
  logic                regWrStrobe;
  logic                regRdStrobe;
  logic [DATA_W-1:0]   regRdData;
  logic                receiverIdleFlag;
  logic                txShiftEmpty;
  logic [2:0]          rxErrorBits;
  logic                rateTick;
  logic                bitTick;
  rate_cfg_t           rateCfg;
  int                  n_fail;
  int                  comparisons;
  logic [DATA_W-1:0]   rdVal;

  serial_baud_rate_generator serial_baud_rate_generator_i (
    .ref_clk          (ref_clk),
    .sys_rst          (sys_rst),
    .regAddr          (regAddr),
    .regWrData        (regWrData),
    .regWrStrobe      (regWrStrobe),
    .regRdStrobe      (regRdStrobe),
    .regRdData        (regRdData),
    .receiverIdleFlag (receiverIdleFlag),
    .txShiftEmpty     (txShiftEmpty),
    .rxErrorBits      (rxErrorBits),
    .rateTick         (rateTick),
    .bitTick          (bitTick),
    .rateCfg          (rateCfg)
  );

  // ==========================================================================
  // Clock, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Returns at the taking edge, strobe already scheduled low
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    regWrStrobe <= 1'b1;
    regAddr     <= a;
    regWrData   <= d;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    regRdStrobe <= 1'b1;
    regAddr     <= a;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd

  // Cycles between two bit ticks and rate ticks inside that span
  task automatic measure(input int n, input int m);
    int cyc;
    int ticks;
    int guard;
    cyc   = 0;
    ticks = 0;
    guard = 0;
    do begin
      @(posedge ref_clk);
      #1;
      guard++;
    end while (bitTick !== 1'b1 && guard < 20000);
    do begin
      @(posedge ref_clk);
      #1;
      cyc++;
      if (rateTick === 1'b1) ticks++;
      if (bitTick === 1'b1) check({31'h0, rateTick}, 32'h1);
    end while (bitTick !== 1'b1 && cyc < 20000);
    check(cyc, m * (n + 1));
    check(ticks, m);
  endtask : measure

  // ==========================================================================
  // Watchdog, well beyond the expected run of about 24000 cycles
  initial begin
    #6000000;
    n_fail++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    int k;
    int m;
    int n;
    logic s;
    logic w;
    logic h;
    sys_rst          = 1'b1;
    regAddr          = 3'h0;
    regWrData        = 8'h00;
    regWrStrobe      = 1'b0;
    regRdStrobe      = 1'b0;
    receiverIdleFlag = 1'b0;
    txShiftEmpty     = 1'b0;
    rxErrorBits      = 3'h0;
    n_fail           = 0;
    comparisons      = 0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;

    // Reset state: 8-bit counter, asynchronous, low speed
    check({29'h0, rateCfg}, 32'h0);
    for (k = 0; k < 8; k++) begin
      rd(k[ADDR_W-1:0], rdVal);
      check({24'h0, rdVal}, 32'h0);
    end

    // Status inputs show through, read-only bits refuse writes
    @(posedge ref_clk);
    receiverIdleFlag <= 1'b1;
    txShiftEmpty     <= 1'b1;
    rxErrorBits      <= 3'h5;
    wr(RATE_CONTROL_IDX, 8'hff);
    wr(RECEIVE_STATUS_CONTROL_IDX, 8'hff);
    wr(TRANSMIT_STATUS_CONTROL_IDX, 8'hff);
    wr(3'h5, 8'hff);
    rd(RATE_CONTROL_IDX, rdVal);
    check({24'h0, rdVal}, 32'h5b);
    rd(RECEIVE_STATUS_CONTROL_IDX, rdVal);
    check({24'h0, rdVal}, 32'hfd);
    rd(TRANSMIT_STATUS_CONTROL_IDX, rdVal);
    check({24'h0, rdVal}, 32'hff);
    rd(3'h5, rdVal);
    check({24'h0, rdVal}, 32'h0);
    check({29'h0, rateCfg}, 32'h7);
    wr(RECEIVE_STATUS_CONTROL_IDX, 8'h00);

    // Every mode; high byte nonzero so the 8-bit modes must ignore it
    wr(RATE_DIVISOR_HIGH_IDX, 8'h01);
    for (k = 0; k < 8; k++) begin
      s = k[2];
      w = k[1];
      h = k[0];
      wr(RATE_CONTROL_IDX, {4'h0, w, 3'h0});
      wr(TRANSMIT_STATUS_CONTROL_IDX, {3'h0, s, 1'b0, h, 2'h0});
      // Wide select waits for a reload, so restart through the divisor
      wr(RATE_DIVISOR_LOW_IDX, 8'h02);
      check({29'h0, rateCfg}, {29'h0, s, w, h});
      n = w ? 258 : 2;
      if (s) m = 4;
      else if (w && h) m = 4;
      else if (w || h) m = 16;
      else m = 64;
      measure(n, m);
    end

    // A divisor write restarts the period at once, from either byte
    wr(RATE_CONTROL_IDX, 8'h00);
    wr(TRANSMIT_STATUS_CONTROL_IDX, 8'h00);
    for (int b = 0; b < 2; b++) begin
      wr(RATE_DIVISOR_LOW_IDX, 8'h40);
      repeat (10) @(posedge ref_clk);
      if (b == 0) wr(RATE_DIVISOR_LOW_IDX, 8'h04);
      else wr(RATE_DIVISOR_HIGH_IDX, 8'h00);
      k = 0;
      do begin
        @(posedge ref_clk);
        #1;
        k++;
      end while (rateTick !== 1'b1 && k < 200);
      n = (b == 0) ? 4 : 64;
      // First sample is the cycle after the restart pulse
      check(k, 2 + n);
    end
    measure(64, 64);
    conclude();
  end

endmodule : tb_top
`default_nettype wire
